/* src/fbp_pkg.sv */
// Package of constants and carrier types for the flash block protection guard
package fbp_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int FBP_ADDR_W = 17;
    localparam int FBP_WORD_ADDR_W = 15;
    localparam int FBP_BLOCK_W = 7;
    localparam int FBP_UNIT_W = 6;
    localparam int FBP_UNITS = 64;
    localparam int FBP_BLOCK_LSB = 10;
    localparam int FBP_UNIT_LSB = 11;
    localparam int FBP_WORD_LSB = 2;
    localparam int FBP_WORDS_PER_BLOCK = 256;
    localparam logic [7:0] FBP_LAST_WORD = 8'hFF;
    localparam logic [31:0] FBP_ERASED_WORD = 32'hFFFFFFFF;
    localparam logic [1:0] FBP_RESET_PROT = 2'h0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        FBP_PROT_OPEN,
        FBP_PROT_READ_ONLY,
        FBP_PROT_EXEC_ONLY,
        FBP_PROT_SPARE
    } fbp_prot_e;

    typedef enum logic [2:0] {
        FBP_OP_NONE,
        FBP_OP_FETCH,
        FBP_OP_DATA_READ,
        FBP_OP_DEBUG_READ,
        FBP_OP_PROGRAM,
        FBP_OP_ERASE
    } fbp_op_e;

    typedef struct packed {
        logic valid;
        fbp_op_e op;
        logic [FBP_ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } fbp_req_s;

    typedef struct packed {
        logic done;
        logic denied;
        logic [31:0] rdata;
    } fbp_rsp_s;

endpackage

/* src/fbp_array.sv */
// Flash word array with single-word program and one-block erase
`timescale 1ns/1ps
module fbp_array (
    input wire logic sys_clk,
    input wire logic clk_en,
    input wire logic rd_en,
    input wire logic wr_en,
    input wire logic erase_en,
    input wire logic [fbp_pkg::FBP_WORD_ADDR_W-1:0] word_addr,
    input wire logic [31:0] wdata,
    output logic [31:0] rdata
);
    logic [31:0] mem [0:(1<<fbp_pkg::FBP_WORD_ADDR_W)-1];
    logic [fbp_pkg::FBP_BLOCK_W-1:0] blk;

    assign blk = word_addr[fbp_pkg::FBP_WORD_ADDR_W-1 -: fbp_pkg::FBP_BLOCK_W];

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (clk_en) begin
            if (erase_en) begin
                for (int i = 0; i < fbp_pkg::FBP_WORDS_PER_BLOCK; i++) begin
                    mem[{blk, 8'(i)}] <= fbp_pkg::FBP_ERASED_WORD;
                end
            end else if (wr_en) begin
                mem[word_addr] <= mem[word_addr] & wdata;
            end
            if (rd_en) begin
                rdata <= mem[word_addr];
            end
        end
    end
endmodule // fbp_array

/* src/fbp_guard.sv */
// Flash protection guard in front of the flash array
// Overview of operation
// - Erase clears exactly one 1 KB block, others stay untouched.
// - Erased block reads back as all ones.
// - One protection setting covers each aligned pair of 1 KB blocks.
// - Read-only units refuse erase and program but allow reads.
// - Execute-only units refuse erase and program.
// - Execute-only units answer only instruction fetches; data and debug reads denied.
// - Address space is 128 KB; every block has protection.
`timescale 1ns/1ps
module fbp_guard (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire fbp_pkg::fbp_req_s req,
    input wire logic prot_wr,
    input wire logic [fbp_pkg::FBP_UNIT_W-1:0] prot_unit,
    input wire fbp_pkg::fbp_prot_e prot_val,
    output fbp_pkg::fbp_rsp_s rsp,
    output logic violation
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [fbp_pkg::FBP_UNITS-1:0][1:0] prot;
        logic pend;
        logic pend_read;
        logic pend_deny;
        logic done;
        logic denied;
        logic violation;
        logic [31:0] rdata;
    } fbp_state_s;

    fbp_state_s st;
    fbp_state_s next_st;
    logic [31:0] arr_rdata;
    logic allow;
    logic is_read;
    logic is_write;
    logic [1:0] unit_prot;
    logic arr_rd;
    logic arr_wr;
    logic arr_erase;
    logic [fbp_pkg::FBP_UNITS-1:0] unit_wr;

    function automatic logic [fbp_pkg::FBP_UNIT_W-1:0] unit_of(
        input logic [fbp_pkg::FBP_ADDR_W-1:0] a);
        unit_of = a[fbp_pkg::FBP_ADDR_W-1:fbp_pkg::FBP_UNIT_LSB];
    endfunction

    function automatic logic permit(input logic [1:0] p, input fbp_pkg::fbp_op_e op);
        logic wr;
        wr = (op == fbp_pkg::FBP_OP_PROGRAM) || (op == fbp_pkg::FBP_OP_ERASE);
        case (p)
            fbp_pkg::FBP_PROT_READ_ONLY: permit = !wr;
            fbp_pkg::FBP_PROT_EXEC_ONLY: permit = (op == fbp_pkg::FBP_OP_FETCH);
            default: permit = 1'b1;
        endcase
    endfunction

    assign unit_prot = st.prot[unit_of(req.addr)];
    assign is_read = req.valid && (req.op == fbp_pkg::FBP_OP_FETCH
        || req.op == fbp_pkg::FBP_OP_DATA_READ || req.op == fbp_pkg::FBP_OP_DEBUG_READ);
    assign is_write = req.valid && (req.op == fbp_pkg::FBP_OP_PROGRAM
        || req.op == fbp_pkg::FBP_OP_ERASE);
    assign allow = permit(unit_prot, req.op);
    assign arr_rd = is_read && allow;
    assign arr_wr = is_write && allow && req.op == fbp_pkg::FBP_OP_PROGRAM;
    assign arr_erase = is_write && allow && req.op == fbp_pkg::FBP_OP_ERASE;

    // ------------------------------------------------------------------
    // Protection write decode
    // ------------------------------------------------------------------
    for (genvar u = 0; u < fbp_pkg::FBP_UNITS; u++) begin : g_unit_wr
        assign unit_wr[u] = prot_wr && (prot_unit == 6'(u));
    end

    // ------------------------------------------------------------------
    // Array
    // ------------------------------------------------------------------
    fbp_array u_array (
        .sys_clk(sys_clk),
        .clk_en(clk_en),
        .rd_en(arr_rd),
        .wr_en(arr_wr),
        .erase_en(arr_erase),
        .word_addr(req.addr[fbp_pkg::FBP_ADDR_W-1:fbp_pkg::FBP_WORD_LSB]),
        .wdata(req.wdata),
        .rdata(arr_rdata)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        next_st.denied = 1'b0;
        next_st.rdata = 32'h00000000;
        for (int u = 0; u < fbp_pkg::FBP_UNITS; u++) begin
            if (unit_wr[u]) begin
                next_st.prot[u] = prot_val;
            end
        end
        next_st.pend = is_read || is_write;
        next_st.pend_read = is_read;
        next_st.pend_deny = (is_read || is_write) && !allow;
        if (st.pend) begin
            next_st.done = 1'b1;
            next_st.denied = st.pend_deny;
            if (st.pend_read && !st.pend_deny) begin
                next_st.rdata = arr_rdata;
            end
            if (st.pend_deny) begin
                next_st.violation = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rsp = fbp_pkg::fbp_rsp_s'({st.done, st.denied, st.rdata});
    assign violation = st.violation;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_RO_NO_WRITE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_en && is_write && unit_prot == fbp_pkg::FBP_PROT_READ_ONLY |-> !allow)
        else $error("read-only unit accepted a write");

    AST_XO_NO_WRITE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_en && is_write && unit_prot == fbp_pkg::FBP_PROT_EXEC_ONLY |-> !allow)
        else $error("execute-only unit accepted a write");

    AST_RO_ARRAY_SAFE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_en && req.valid && st.prot[req.addr[fbp_pkg::FBP_ADDR_W-1:fbp_pkg::FBP_UNIT_LSB]]
        == fbp_pkg::FBP_PROT_READ_ONLY |-> !arr_wr && !arr_erase)
        else $error("read-only unit reached the array with a write");

    AST_XO_ARRAY_SAFE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_en && req.valid && st.prot[req.addr[fbp_pkg::FBP_ADDR_W-1:fbp_pkg::FBP_UNIT_LSB]]
        == fbp_pkg::FBP_PROT_EXEC_ONLY
        |-> !arr_wr && !arr_erase && (!arr_rd || req.op == fbp_pkg::FBP_OP_FETCH))
        else $error("execute-only unit reached the array");

    AST_RO_DENY_RSP: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_en && is_write && unit_prot == fbp_pkg::FBP_PROT_READ_ONLY
        ##1 clk_en ##1 clk_en |-> rsp.done && rsp.denied)
        else $error("read-only write not answered as denied");

    AST_XO_WRITE_DENY_RSP: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_en && is_write && unit_prot == fbp_pkg::FBP_PROT_EXEC_ONLY
        ##1 clk_en ##1 clk_en |-> rsp.done && rsp.denied)
        else $error("execute-only write not answered as denied");

    AST_ERASE_ONE_BLOCK: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_en && req.valid && req.op == fbp_pkg::FBP_OP_ERASE && allow |-> arr_erase && !arr_wr)
        else $error("allowed erase did not reach the array");

    AST_PROT_WRITE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_en && prot_wr |=> st.prot[$past(prot_unit)] == $past(prot_val))
        else $error("protection write not stored");

    AST_OPEN_OK: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_en && req.valid && unit_prot == fbp_pkg::FBP_PROT_OPEN |-> allow)
        else $error("open unit refused a request");

    // ------------------------------------------------------------------
    // Read checks
    // ------------------------------------------------------------------
    AST_XO_DATA_DENY: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_en && is_read && req.op != fbp_pkg::FBP_OP_FETCH
        && unit_prot == fbp_pkg::FBP_PROT_EXEC_ONLY ##1 clk_en ##1 clk_en |-> rsp.denied)
        else $error("execute-only data read not denied");

    AST_XO_FETCH_OK: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_en && req.valid && req.op == fbp_pkg::FBP_OP_FETCH
        && unit_prot == fbp_pkg::FBP_PROT_EXEC_ONLY ##1 clk_en ##1 clk_en |-> !rsp.denied)
        else $error("execute-only fetch refused");

    AST_RO_READ_OK: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_en && is_read && unit_prot == fbp_pkg::FBP_PROT_READ_ONLY |-> allow)
        else $error("read-only unit refused a read");

    AST_RO_READ_RSP: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_en && is_read && unit_prot == fbp_pkg::FBP_PROT_READ_ONLY
        ##1 clk_en ##1 clk_en |-> rsp.done && !rsp.denied)
        else $error("read-only read answered as denied");

    AST_DENY_NO_DATA: assert property (@(posedge sys_clk) disable iff (!reset_n)
        rsp.denied |-> rsp.rdata == 32'h00000000)
        else $error("denied access returned data");

    // ------------------------------------------------------------------
    // Completion and violation flag checks
    // ------------------------------------------------------------------
    AST_DONE_TWO: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_en && (is_read || is_write) ##1 clk_en ##1 clk_en |-> rsp.done)
        else $error("request did not complete in two cycles");

    AST_IDLE_NO_DONE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_en && !(is_read || is_write) ##1 clk_en ##1 clk_en |-> !rsp.done)
        else $error("completion without a request");

    AST_WRITE_NO_DATA: assert property (@(posedge sys_clk) disable iff (!reset_n)
        clk_en && is_write ##1 clk_en ##1 clk_en |-> rsp.rdata == 32'h00000000)
        else $error("write answered with data");

    AST_DENY_WITH_DONE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        rsp.denied |-> rsp.done)
        else $error("denial without completion");

    AST_VIOL_STICKY: assert property (@(posedge sys_clk) disable iff (!reset_n)
        rsp.denied |-> violation ##1 violation)
        else $error("violation flag not raised or lost");

    AST_VIOL_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n)
        violation |=> violation)
        else $error("violation flag dropped before reset");

    AST_VIOL_CAUSE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(violation) |-> rsp.denied)
        else $error("violation flag raised without a denial");
endmodule // fbp_guard

/* bench/fbp_cpu_model.sv */
// Processor fetch, data and debug port model issuing flash requests
`timescale 1ns/1ps
module fbp_cpu_model (
    input wire logic sys_clk,
    output fbp_pkg::fbp_req_s req
);
    initial begin
        req = '0;
    end
    // One request held for one taking edge, then released with inverted lines
    task automatic send(input fbp_pkg::fbp_op_e op, input logic [16:0] addr,
                        input logic [31:0] wdata);
        @(posedge sys_clk);
        req <= '{1'b1, op, addr, wdata};
        @(posedge sys_clk);
        req <= '{1'b0, fbp_pkg::FBP_OP_NONE, ~addr, ~wdata};
    endtask
endmodule // fbp_cpu_model

/* bench/flash_block_protection_bench.sv */
// Self-checking bench for the flash protection guard
`timescale 1ns/1ps
module flash_block_protection_bench;
    typedef struct packed {
        fbp_pkg::fbp_op_e op;
        logic [16:0] addr;
        logic [31:0] wdata;
        logic denied;
        logic [31:0] rdata;
    } fbp_row_s;
    localparam fbp_pkg::fbp_op_e op_er = fbp_pkg::FBP_OP_ERASE;
    localparam fbp_pkg::fbp_op_e op_pg = fbp_pkg::FBP_OP_PROGRAM;
    localparam fbp_pkg::fbp_op_e op_dr = fbp_pkg::FBP_OP_DATA_READ;
    localparam fbp_pkg::fbp_op_e op_db = fbp_pkg::FBP_OP_DEBUG_READ;
    localparam fbp_pkg::fbp_op_e op_fe = fbp_pkg::FBP_OP_FETCH;
    localparam fbp_pkg::fbp_op_e op_pr = fbp_pkg::FBP_OP_NONE;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic prot_wr = 1'b0;
    logic [5:0] prot_unit = 6'h00;
    fbp_pkg::fbp_prot_e prot_val = fbp_pkg::FBP_PROT_OPEN;
    fbp_pkg::fbp_req_s req;
    fbp_pkg::fbp_rsp_s rsp;
    logic violation;
    logic exp_vio;
    int n_errors = 0;
    int check_count = 0;
    // Protection writes use op_pr: unit from addr, setting from wdata
    fbp_row_s rows [22] = '{
        '{op_er, 17'h00000, 32'h0, 1'b0, 32'h0},
        '{op_er, 17'h00400, 32'h0, 1'b0, 32'h0},
        '{op_er, 17'h1FC00, 32'h0, 1'b0, 32'h0},
        '{op_er, 17'h00800, 32'h0, 1'b0, 32'h0},
        '{op_pg, 17'h00400, 32'hA5A50F0F, 1'b0, 32'h0},
        '{op_pg, 17'h00000, 32'h12345678, 1'b0, 32'h0},
        '{op_dr, 17'h00000, 32'h0, 1'b0, 32'h12345678},
        '{op_er, 17'h00000, 32'h0, 1'b0, 32'h0},
        '{op_dr, 17'h00000, 32'h0, 1'b0, 32'hFFFFFFFF},
        '{op_db, 17'h00400, 32'h0, 1'b0, 32'hA5A50F0F},
        '{op_pr, 17'h00000, 32'h1, 1'b0, 32'h0},
        '{op_pg, 17'h00404, 32'h0, 1'b1, 32'h0},
        '{op_er, 17'h00400, 32'h0, 1'b1, 32'h0},
        '{op_dr, 17'h00400, 32'h0, 1'b0, 32'hA5A50F0F},
        '{op_er, 17'h00800, 32'h0, 1'b0, 32'h0},
        '{op_pr, 17'h1F800, 32'h2, 1'b0, 32'h0},
        '{op_fe, 17'h1FC00, 32'h0, 1'b0, 32'hFFFFFFFF},
        '{op_dr, 17'h1FC00, 32'h0, 1'b1, 32'h0},
        '{op_db, 17'h1FFFC, 32'h0, 1'b1, 32'h0},
        '{op_pg, 17'h1FC00, 32'h0, 1'b1, 32'h0},
        '{op_er, 17'h1F800, 32'h0, 1'b1, 32'h0},
        '{op_fe, 17'h1FC00, 32'h0, 1'b0, 32'hFFFFFFFF}
    };
    always #2 sys_clk = ~sys_clk;
    fbp_cpu_model cpu_u (.sys_clk(sys_clk), .req(req));
    fbp_guard dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .req(req),
        .prot_wr(prot_wr), .prot_unit(prot_unit), .prot_val(prot_val), .rsp(rsp),
        .violation(violation));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("errors %0d, checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // One row: protection write, or request with its answer two edges on
    task automatic run(input fbp_row_s r);
        if (r.op == op_pr) begin
            @(posedge sys_clk);
            prot_wr <= 1'b1;
            prot_unit <= r.addr[16:11];
            prot_val <= fbp_pkg::fbp_prot_e'(r.wdata[1:0]);
            @(posedge sys_clk);
            prot_wr <= 1'b0;
        end else begin
            cpu_u.send(r.op, r.addr, r.wdata);
            @(posedge sys_clk);
            #1;
            exp_vio = exp_vio | r.denied;
            check(32'(rsp.done), 32'h1);
            check(32'(rsp.denied), 32'(r.denied));
            check(rsp.rdata, r.rdata);
            check(32'(violation), 32'(exp_vio));
        end
    endtask
    initial begin
        #20000;
        n_errors++;
        print_verdict();
    end
    initial begin
        exp_vio = 1'b0;
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            run(rows[i]);
        end
        // Reset in mid-run clears the flag and reopens every unit
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        check(32'(violation), 32'h0);
        check(32'(rsp.done), 32'h0);
        @(posedge sys_clk);
        reset_n <= 1'b1;
        exp_vio = 1'b0;
        run(fbp_row_s'{op_pg, 17'h1FC00, 32'h0000FFFF, 1'b0, 32'h0});
        run(fbp_row_s'{op_dr, 17'h1FC00, 32'h0, 1'b0, 32'h0000FFFF});
        // Spare setting acts as open
        run(fbp_row_s'{op_pr, 17'h1F800, 32'h3, 1'b0, 32'h0});
        run(fbp_row_s'{op_pg, 17'h1FC00, 32'h0000FF00, 1'b0, 32'h0});
        // Clock enable low freezes an answer in flight
        cpu_u.send(op_fe, 17'h1FC00, 32'h0);
        clk_en <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        check(32'(rsp.done), 32'h0);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        @(posedge sys_clk);
        #1;
        check(32'(rsp.done), 32'h1);
        check(32'(rsp.denied), 32'h0);
        check(rsp.rdata, 32'h0000FF00);
        print_verdict();
    end
endmodule // flash_block_protection_bench
